// *** pkg/dsps_params.svh ***
// Behaviour
// - primary valid after all three comparators high 64 ms
// - switchover sense low moves output to backup
// - backup valid: above minimum and uv sense high
// - neither valid: backup only if disconnect high
// - break primary, arm reverse detector, then make
// - return to primary after requalify: break backup, wait for primary_reverse_ok, then make
// - connect only when output 50 mV below input
// - drop channel when input below drop threshold
// - internal supply from priority input or higher
// - disconnect low: open backup path when invalid
// - backup good latched at window end
// - backup good held between windows
// - monitoring suspended below minimum or thermal shutdown
// - power-up: monitoring off, backup good low
// - ground switch low for each monitor window, registered one clock late
// - primary valid: test input gates monitoring
// - primary invalid: always monitor, pick duty cycle
// - aux flag low when input low or power-up
// - seal mode exits after 32 ms qualification
// - disconnect input initialised high at power-up
// - monitor events spaced about 132 seconds with test enabled, 8800 otherwise
`ifndef DSPS_PARAMS_SVH
`define DSPS_PARAMS_SVH
`define DSPS_CLK_HZ 100000000
`define DSPS_QUAL_MS 64
`define DSPS_SEAL_MS 32
`define DSPS_WIN_LONG_MS 128
`define DSPS_WIN_SHORT_MS 2
`define DSPS_GAP_S 132
`define DSPS_GAP_SLOW_S 8800
`define DSPS_CYC_PER_MS (`DSPS_CLK_HZ / 1000)
`define DSPS_CYC_PER_S `DSPS_CLK_HZ
`define DSPS_BG_RESET 1'b0
`define DSPS_DIS_RESET 1'b1
`endif

// *** pkg/dsps_pkg.sv ***
package dsps_pkg;
	typedef enum logic [3:0] {
		DSPS_OFF = 4'b0001,
		DSPS_PRI = 4'b0010,
		DSPS_BREAK = 4'b0100,
		DSPS_BAK = 4'b1000
	} dsps_path_e;
endpackage

// *** hw/dsps_selector.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dsps_params.svh"
module dsps_selector #(
	parameter longint QUAL_CYC = 64'(`DSPS_QUAL_MS * `DSPS_CYC_PER_MS),
	parameter longint SEAL_CYC = 64'(`DSPS_SEAL_MS * `DSPS_CYC_PER_MS),
	parameter longint WIN_LONG_CYC = 64'(`DSPS_WIN_LONG_MS * `DSPS_CYC_PER_MS),
	parameter longint WIN_SHORT_CYC = 64'(`DSPS_WIN_SHORT_MS * `DSPS_CYC_PER_MS),
	parameter longint GAP_CYC = 64'(`DSPS_GAP_S) * `DSPS_CYC_PER_S,
	parameter longint GAP_SLOW_CYC = 64'(`DSPS_GAP_SLOW_S) * `DSPS_CYC_PER_S
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// digitized comparators
	input wire logic primary_min_ok,
	input wire logic primary_uv_comparator,
	input wire logic switchover_comparator,
	input wire logic primary_drop_ok,
	input wire logic backup_min_ok,
	input wire logic backup_drop_ok,
	input wire logic backup_uv_sense,
	input wire logic backup_reverse_detector,
	input wire logic primary_reverse_ok,
	input wire logic aux_comparator,
	input wire logic backup_higher,
	input wire logic thermal_shutdown,
	// host pins
	input wire logic backup_test_enable,
	input wire logic backup_disconnect_n_in,
	input wire logic seal_mode,
	// control outputs
	output logic primary_path_on,
	output logic backup_path_on,
	output logic backup_reverse_enable,
	output logic icc_from_backup,
	output logic divider_ground_switch_out,
	output logic divider_ground_switch_oe,
	output logic backup_good,
	output logic aux_monitor_flag_n_out,
	output logic aux_monitor_flag_n_oe,
	output logic backup_disconnect_n_out,
	output logic backup_disconnect_n_oe,
	output logic seal_exit
);
	// ==========================
	// primary qualification
	logic [63:0] qual_cnt_r;
	logic primary_valid_r;
	logic pri_raw;
	assign pri_raw = primary_min_ok & primary_uv_comparator & switchover_comparator;
	always_ff @(posedge clk_sys) begin
		if (reset || !pri_raw) begin
			qual_cnt_r <= 64'h0;
			primary_valid_r <= 1'b0;
		end else if (qual_cnt_r >= 64'(QUAL_CYC - 1)) begin
			primary_valid_r <= 1'b1;
		end else begin
			qual_cnt_r <= qual_cnt_r + 64'h1;
		end
	end
	// ==========================
	// seal exit qualification
	logic [63:0] seal_cnt_r;
	always_ff @(posedge clk_sys) begin
		if (reset || !seal_mode || !pri_raw) begin
			seal_cnt_r <= 64'h0;
			seal_exit <= 1'b0;
		end else if (seal_cnt_r >= 64'(SEAL_CYC - 1)) begin
			seal_exit <= 1'b1;
		end else begin
			seal_cnt_r <= seal_cnt_r + 64'h1;
		end
	end
	// ==========================
	// backup monitoring
	logic [63:0] mon_cnt_r;
	logic mon_win_r;
	logic powered_r;
	logic mon_allowed;
	logic [63:0] win_len;
	logic [63:0] gap_len;
	assign mon_allowed = powered_r && backup_min_ok && !thermal_shutdown
		&& (!primary_valid_r || backup_test_enable);
	// long window when testing enabled, short when idle and backup already bad
	assign win_len = (backup_test_enable || backup_good) ? 64'(WIN_LONG_CYC)
		: 64'(WIN_SHORT_CYC);
	assign gap_len = backup_test_enable ? 64'(GAP_CYC) : 64'(GAP_SLOW_CYC);
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			powered_r <= 1'b0;
		end else begin
			powered_r <= 1'b1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (reset || !mon_allowed) begin
			mon_cnt_r <= 64'h0;
			mon_win_r <= 1'b0;
		end else if (!mon_win_r && mon_cnt_r >= gap_len - 64'h1) begin
			mon_cnt_r <= 64'h0;
			mon_win_r <= 1'b1;
		end else if (mon_win_r && mon_cnt_r >= win_len - 64'h1) begin
			mon_cnt_r <= 64'h0;
			mon_win_r <= 1'b0;
		end else begin
			mon_cnt_r <= mon_cnt_r + 64'h1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			divider_ground_switch_out <= 1'b0;
			divider_ground_switch_oe <= 1'b0;
		end else begin
			divider_ground_switch_oe <= mon_win_r && mon_allowed;
			divider_ground_switch_out <= 1'b0;
		end
	end
	// valid verdict taken at the window end, held otherwise
	logic win_end;
	assign win_end = mon_win_r && mon_allowed && mon_cnt_r >= win_len - 64'h1;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			backup_good <= `DSPS_BG_RESET;
		end else if (win_end) begin
			backup_good <= backup_min_ok & backup_uv_sense;
		end
	end
	// ==========================
	// path selection
	dsps_pkg::dsps_path_e path_r;
	logic want_backup;
	assign want_backup = backup_min_ok && backup_drop_ok
		&& (backup_disconnect_n_in || backup_good);
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			path_r <= dsps_pkg::DSPS_OFF;
		end else begin
			case (path_r)
				dsps_pkg::DSPS_OFF: begin
					if (primary_valid_r && primary_drop_ok && primary_reverse_ok) begin
						path_r <= dsps_pkg::DSPS_PRI;
					end else if (!primary_valid_r && want_backup) begin
						path_r <= dsps_pkg::DSPS_BREAK;
					end
				end
				dsps_pkg::DSPS_PRI: begin
					if (!primary_valid_r || !primary_drop_ok) begin
						path_r <= dsps_pkg::DSPS_OFF;
					end
				end
				dsps_pkg::DSPS_BREAK: begin
					if (primary_valid_r || !want_backup) begin
						path_r <= dsps_pkg::DSPS_OFF;
					end else if (backup_reverse_detector) begin
						path_r <= dsps_pkg::DSPS_BAK;
					end
				end
				dsps_pkg::DSPS_BAK: begin
					if (primary_valid_r || !want_backup) begin
						path_r <= dsps_pkg::DSPS_OFF;
					end
				end
				default: path_r <= dsps_pkg::DSPS_OFF;
			endcase
		end
	end
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			primary_path_on <= 1'b0;
			backup_path_on <= 1'b0;
			backup_reverse_enable <= 1'b0;
		end else begin
			primary_path_on <= path_r == dsps_pkg::DSPS_PRI;
			backup_path_on <= path_r == dsps_pkg::DSPS_BAK;
			backup_reverse_enable <= path_r == dsps_pkg::DSPS_BREAK;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			icc_from_backup <= 1'b0;
		end else if (primary_min_ok || backup_min_ok) begin
			icc_from_backup <= !primary_valid_r && backup_min_ok;
		end else begin
			icc_from_backup <= backup_higher;
		end
	end
	// ==========================
	// open-drain pins
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			aux_monitor_flag_n_out <= 1'b0;
			aux_monitor_flag_n_oe <= 1'b1;
			backup_disconnect_n_out <= `DSPS_DIS_RESET;
			backup_disconnect_n_oe <= 1'b1;
		end else begin
			aux_monitor_flag_n_out <= 1'b0;
			aux_monitor_flag_n_oe <= !aux_comparator || !powered_r;
			backup_disconnect_n_out <= `DSPS_DIS_RESET;
			backup_disconnect_n_oe <= !powered_r;
		end
	end
	// ==========================
	// checks
	property p_qual;
		@(posedge clk_sys) disable iff (reset) $rose(primary_valid_r) |-> $past(pri_raw);
	endproperty
	a_qual: assert property (p_qual) else $error("primary valid without inputs");
	property p_drop;
		@(posedge clk_sys) disable iff (reset) !pri_raw |=> !primary_valid_r;
	endproperty
	a_drop: assert property (p_drop) else $error("primary valid kept after drop");
	sequence s_break;
		path_r == dsps_pkg::DSPS_BREAK;
	endsequence
	property p_bbm;
		@(posedge clk_sys) disable iff (reset)
			$rose(path_r == dsps_pkg::DSPS_BAK) |-> $past(path_r == dsps_pkg::DSPS_BREAK);
	endproperty
	a_bbm: assert property (p_bbm) else $error("backup made without break");
	property p_rev;
		@(posedge clk_sys) disable iff (reset) s_break ##1 path_r == dsps_pkg::DSPS_BAK
			|-> $past(backup_reverse_detector);
	endproperty
	a_rev: assert property (p_rev) else $error("backup made without reverse clear");
	property p_excl;
		@(posedge clk_sys) disable iff (reset) !(primary_path_on && backup_path_on);
	endproperty
	a_excl: assert property (p_excl) else $error("both paths on");
	property p_hold;
		@(posedge clk_sys) disable iff (reset) !win_end |=> $stable(backup_good);
	endproperty
	a_hold: assert property (p_hold) else $error("backup good changed off window");
	property p_gnd;
		@(posedge clk_sys) disable iff (reset)
			divider_ground_switch_oe |-> $past(mon_win_r);
	endproperty
	a_gnd: assert property (p_gnd) else $error("ground switch outside window");
	property p_sus;
		@(posedge clk_sys) disable iff (reset) thermal_shutdown |=> !mon_win_r;
	endproperty
	a_sus: assert property (p_sus) else $error("monitoring during shutdown");
	property p_aux;
		@(posedge clk_sys) disable iff (reset) !aux_comparator |=> aux_monitor_flag_n_oe;
	endproperty
	a_aux: assert property (p_aux) else $error("aux flag not pulled low");
	property p_pri_make;
		@(posedge clk_sys) disable iff (reset)
			$rose(primary_path_on) |-> $past(primary_valid_r, 2) && $past(primary_reverse_ok, 2);
	endproperty
	a_pri_make: assert property (p_pri_make) else $error("primary made while unqualified");
	property p_rev_only;
		@(posedge clk_sys) disable iff (reset)
			backup_reverse_enable |-> !primary_path_on && !backup_path_on;
	endproperty
	a_rev_only: assert property (p_rev_only) else $error("reverse detector armed with path on");
	property p_bak_make;
		@(posedge clk_sys) disable iff (reset)
			$rose(backup_path_on) |-> $past(backup_reverse_enable);
	endproperty
	a_bak_make: assert property (p_bak_make) else $error("backup made before detector armed");
	property p_pri_cut;
		@(posedge clk_sys) disable iff (reset)
			primary_path_on && !primary_drop_ok |-> ##2 !primary_path_on;
	endproperty
	a_pri_cut: assert property (p_pri_cut) else $error("primary kept after drop");
	property p_bak_cut;
		@(posedge clk_sys) disable iff (reset)
			backup_path_on && !backup_drop_ok |-> ##2 !backup_path_on;
	endproperty
	a_bak_cut: assert property (p_bak_cut) else $error("backup kept after drop");
	property p_return;
		@(posedge clk_sys) disable iff (reset)
			primary_valid_r && backup_path_on |-> ##2 !backup_path_on;
	endproperty
	a_return: assert property (p_return) else $error("backup kept after requalify");
	property p_icc;
		@(posedge clk_sys) disable iff (reset)
			!primary_valid_r && backup_min_ok |=> icc_from_backup;
	endproperty
	a_icc: assert property (p_icc) else $error("internal supply not from backup");
	property p_seal;
		@(posedge clk_sys) disable iff (reset)
			seal_exit |-> $past(seal_mode) && $past(pri_raw);
	endproperty
	a_seal: assert property (p_seal) else $error("seal exit without qualified primary");
	property p_gnd_off;
		@(posedge clk_sys) disable iff (reset)
			!mon_allowed |=> !divider_ground_switch_oe;
	endproperty
	a_gnd_off: assert property (p_gnd_off) else $error("ground switch while not allowed");
	property p_good_end;
		@(posedge clk_sys) disable iff (reset)
			win_end |=> backup_good == ($past(backup_min_ok) && $past(backup_uv_sense));
	endproperty
	a_good_end: assert property (p_good_end) else $error("backup good verdict wrong");
	property p_dis_high;
		@(posedge clk_sys) disable iff (reset)
			backup_disconnect_n_oe |-> backup_disconnect_n_out;
	endproperty
	a_dis_high: assert property (p_dis_high) else $error("disconnect pin not driven high");
	property p_aux_pow;
		@(posedge clk_sys) disable iff (reset)
			!powered_r |=> aux_monitor_flag_n_oe;
	endproperty
	a_aux_pow: assert property (p_aux_pow) else $error("aux flag released at power-up");
endmodule // dsps_selector
`default_nettype wire

// *** tb/dsps_supply_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// =====
// supplies, output node and host pins
module dsps_supply_model (
	// clock
	input wire logic clk_sys,
	// bench supply state
	input wire logic uv_ok,
	input wire logic host_dis_n,
	// device side
	input wire logic pri_on,
	input wire logic bak_on,
	input wire logic rev_en,
	input wire logic gnd_oe,
	input wire logic dis_out,
	input wire logic dis_oe,
	output logic backup_uv_sense,
	output logic backup_reverse_detector,
	output logic primary_reverse_ok,
	output logic backup_disconnect_n_in
);
	logic [2:0] droop_r = 3'h0;
	// output sags while no path feeds it
	always_ff @(posedge clk_sys) begin
		if (pri_on | bak_on)
			droop_r <= 3'h0;
		else if (droop_r != 3'h7)
			droop_r <= droop_r + 3'h1;
	end
	assign backup_reverse_detector = rev_en & (droop_r >= 3'h4);
	assign primary_reverse_ok = droop_r >= 3'h4;
	// divider floats to the battery level unless grounded
	assign backup_uv_sense = gnd_oe ? uv_ok : 1'b1;
	assign backup_disconnect_n_in = host_dis_n & (~dis_oe | dis_out);
endmodule // dsps_supply_model
`default_nettype wire

// *** tb/dsps_selector_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module dsps_selector_tb;
	localparam int Q = 20;
	localparam int S = 10;
	localparam int WL = 6;
	localparam int WS = 3;
	localparam int G = 30;
	localparam int GS = 60;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic p_min = 1'b0, p_uv = 1'b0, p_sw = 1'b0, th = 1'b0, tst = 1'b1, seal = 1'b0;
	logic aux = 1'b1, uv_ok = 1'b1, hdis = 1'b1, last = 1'b0;
	logic bsns, brev, prok, dis_in, pri_on, bak_on, rev_en, icc, gnd_oe, bgood;
	logic aux_oe, dis_out, dis_oe, sx;
	int bad_count = 0, tests_run = 0, cyc = 0, wins = 0, n, k;
	// =====
	// design and far side
	dsps_selector #(.QUAL_CYC(Q), .SEAL_CYC(S), .WIN_LONG_CYC(WL), .WIN_SHORT_CYC(WS),
		.GAP_CYC(G), .GAP_SLOW_CYC(GS)) dsps_selector_i (
		.clk_sys(clk_sys), .reset(reset), .primary_min_ok(p_min),
		.primary_uv_comparator(p_uv), .switchover_comparator(p_sw), .primary_drop_ok(1'b1),
		.backup_min_ok(1'b1), .backup_drop_ok(1'b1), .backup_uv_sense(bsns),
		.backup_reverse_detector(brev), .primary_reverse_ok(prok), .aux_comparator(aux),
		.backup_higher(1'b1), .thermal_shutdown(th), .backup_test_enable(tst),
		.backup_disconnect_n_in(dis_in), .seal_mode(seal), .primary_path_on(pri_on),
		.backup_path_on(bak_on), .backup_reverse_enable(rev_en), .icc_from_backup(icc),
		.divider_ground_switch_out(), .divider_ground_switch_oe(gnd_oe), .backup_good(bgood),
		.aux_monitor_flag_n_out(), .aux_monitor_flag_n_oe(aux_oe),
		.backup_disconnect_n_out(dis_out), .backup_disconnect_n_oe(dis_oe), .seal_exit(sx));
	dsps_supply_model dsps_supply_model_i (.clk_sys(clk_sys), .uv_ok(uv_ok),
		.host_dis_n(hdis), .pri_on(pri_on), .bak_on(bak_on), .rev_en(rev_en),
		.gnd_oe(gnd_oe), .dis_out(dis_out), .dis_oe(dis_oe), .backup_uv_sense(bsns),
		.backup_reverse_detector(brev), .primary_reverse_ok(prok),
		.backup_disconnect_n_in(dis_in));
	// =====
	// helpers
	function automatic logic exp_good(input logic min_ok, input logic uv);
		return min_ok & uv;
	endfunction
	function automatic logic pick(input int w);
		case (w)
			0: return pri_on;
			1: return bak_on;
			2: return gnd_oe;
			3: return sx;
			default: return aux_oe;
		endcase
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wt(input int w, input logic v, input int lim);
		#1;
		n = 0;
		while (pick(w) !== v && n < lim) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk(pick(w), v);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial forever #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (gnd_oe === 1'b1)
			wins <= wins + 1;
		if (cyc == 2000) begin
			bad_count++;
			print_verdict;
		end
	end
	// =====
	// scenarios
	initial begin
		k = $urandom(32'h089CD5DE);
		repeat (8) @(posedge clk_sys);
		#1;
		chk({pri_on, bak_on, bgood, aux_oe, dis_oe, dis_out}, 6'h07);
		@(posedge clk_sys);
		reset <= 1'b0;
		wt(4, 1'b0, 8);
		@(posedge clk_sys);
		aux <= 1'b0;
		wt(4, 1'b1, 4);
		wt(1, 1'b1, 30);
		chk(icc, 1'b1);
		for (int i = 0; i < 3; i++) begin
			k = (i < 2) ? i : $urandom_range(1, 0);
			@(posedge clk_sys);
			uv_ok <= k[0];
			hdis <= k[0];
			wt(2, 1'b1, GS + WL + 4);
			chk(bgood, last);
			wt(2, 1'b0, WL + 2);
			chk(n == WS || n == WL, 1'b1);
			repeat (2) @(posedge clk_sys);
			#1;
			chk(bgood, exp_good(1'b1, k[0]));
			last = k[0];
			if (!k[0])
				chk(bak_on, 1'b0);
		end
		@(posedge clk_sys);
		{uv_ok, hdis, p_min, p_uv, p_sw} <= 5'h1F;
		k = $urandom_range(Q - 3, 3);
		repeat (k) @(posedge clk_sys);
		p_uv <= 1'b0;
		@(posedge clk_sys);
		p_uv <= 1'b1;
		wt(0, 1'b1, Q + 16);
		chk(n >= Q - 1, 1'b1);
		chk({bak_on, icc}, 2'h0);
		@(posedge clk_sys);
		tst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		wt(2, 1'b0, WL + 2);
		k = wins;
		repeat (G + WL + 8) @(posedge clk_sys);
		chk(wins == k, 1'b1);
		tst <= 1'b1;
		wt(2, 1'b1, G + WL + 8);
		wt(2, 1'b0, WL + 2);
		@(posedge clk_sys);
		p_sw <= 1'b0;
		wt(0, 1'b0, 4);
		wt(1, 1'b1, 16);
		chk(n >= 4, 1'b1);
		@(posedge clk_sys);
		{seal, p_sw} <= 2'h3;
		wt(3, 1'b1, S + 8);
		chk(n >= S - 1, 1'b1);
		@(posedge clk_sys);
		{p_min, th} <= 2'h1;
		repeat (2) @(posedge clk_sys);
		wt(2, 1'b0, WL + 2);
		k = wins;
		repeat (GS + WL + 8) @(posedge clk_sys);
		chk(wins == k, 1'b1);
		print_verdict;
	end
endmodule // dsps_selector_tb
`default_nettype wire
